// ---- common/hbp_defs.svh ----
/*
   Constants of the host byte port: pin positions in the general-purpose
   map, register-select codes, status fields and reset values.
   Assumes it is included by its bare name from every design file.
*/
`ifndef HBP_DEFS_SVH
`define HBP_DEFS_SVH

// Pin positions when the port pins serve as general-purpose bits.
`define HBP_PIN_COUNT      15
`define HBP_PIN_BYTE_LO    0
`define HBP_PIN_BYTE_HI    7
`define HBP_PIN_SEL_LO     8
`define HBP_PIN_SEL_HI     10
`define HBP_PIN_DIR        11
`define HBP_PIN_STB        12
`define HBP_PIN_REQ        13
`define HBP_PIN_ACK        14

// Register-select codes decoded for each host access.
`define HBP_SEL_DATA       3'h0
`define HBP_SEL_STATUS     3'h1

// Status byte fields.
`define HBP_STAT_TX_FULL   0
`define HBP_STAT_RX_SPACE  1
`define HBP_STAT_OVERRUN   2

// Reset values and the all-driven output-enable pattern.
`define HBP_BYTE_RST       8'h00
`define HBP_OE_NONE        8'h00
`define HBP_OE_ALL         8'hFF
`define HBP_SEL_RST        3'h0

`endif

// ---- common/hbp_pkg.sv ----
/*
   Types of the host byte port.
   Assumes hbp_defs.svh supplies the numeric constants.
*/
package hbp_pkg;

   // Kind of host access held while the strobe or acknowledge is low.
   typedef enum logic [1:0] {
      HBP_ACC_NONE,
      HBP_ACC_READ,
      HBP_ACC_WRITE
   } hbp_access_t;

endpackage

// ---- design/hbp_pin_cell.sv ----
/*
   One port pin: host function or general-purpose bit, registered drive.
   Assumes the pad input is synchronous to clock and that the pad wire is
   resolved outside from pad_out and pad_oe.
*/
`timescale 1ns/10ps
`default_nettype none
`include "hbp_defs.svh"

module hbp_pin_cell
#(
   parameter bit OPEN_DRAIN = 1'b0
)
(
   input  wire logic clock,
   input  wire logic rst_n,
   input  wire logic host_mode,
   input  wire logic host_drive,
   input  wire logic host_value,
   input  wire logic gpio_oe,
   input  wire logic gpio_value,
   input  wire logic pad_in,
   output var  logic pad_out,
   output var  logic pad_oe,
   output var  logic gpio_in
);

   // Drive state; reset leaves the pin an undriven input.
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         pad_oe  <= 1'b0;
         pad_out <= 1'b0;
      end
      else if (host_mode && OPEN_DRAIN)
      begin
         pad_oe  <= ~host_value; // Only ever pulls low; a pull-up gives high.
         pad_out <= 1'b0;
      end
      else if (host_mode)
      begin
         pad_oe  <= host_drive;
         pad_out <= host_value;
      end
      else
      begin
         pad_oe  <= gpio_oe;
         pad_out <= gpio_value;
      end
   end

   // Pin level as seen by the general-purpose reader.
   always_ff @(posedge clock)
   begin
      if (!rst_n)
         gpio_in <= 1'b0;
      else
         gpio_in <= pad_in;
   end

endmodule
`default_nettype wire

// ---- design/hbp_pair_buf.sv ----
/*
   Small buffer with valid and ready on both sides; two entries by default.
   Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/10ps
`default_nettype none
`include "hbp_defs.svh"

module hbp_pair_buf
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 2
)
(
   input  wire logic             clock,
   input  wire logic             rst_n,
   input  wire logic             in_valid,
   output var  logic             in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output var  logic             out_valid,
   input  wire logic             out_ready,
   output var  logic [WIDTH-1:0] out_data
);

   logic [WIDTH-1:0] slot_reg [DEPTH];
   logic [DEPTH-1:0] full_reg;
   logic             push;
   logic             pop;

   // Entry 0 is the head; entries shift toward it on a pop.
   assign push      = in_valid & ~full_reg[DEPTH-1];
   assign pop       = out_ready & full_reg[0];
   assign in_ready  = ~full_reg[DEPTH-1];
   assign out_valid = full_reg[0];
   assign out_data  = slot_reg[0];

   // Occupancy as a thermometer so that full and empty are single flops.
   always_ff @(posedge clock)
   begin
      if (!rst_n)
         full_reg <= '0;
      else if (push && !pop)
         full_reg <= {full_reg[DEPTH-2:0], 1'b1};
      else if (pop && !push)
         full_reg <= {1'b0, full_reg[DEPTH-1:1]};
   end

   // Storage: shift on pop, write the first free slot on push.
   always_ff @(posedge clock)
   begin
      for (int i = 0; i < DEPTH; i++)
      begin
         if (pop)
         begin
            if (i < DEPTH - 1)
               slot_reg[i] <= slot_reg[i+1];
            if (push && (i < DEPTH - 1) && full_reg[i+1] && !
               ((i < DEPTH - 2) ? full_reg[(i+2) % DEPTH] : 1'b0))
               slot_reg[i] <= in_data;
            if (push && (i == 0) && !full_reg[1])
               slot_reg[i] <= in_data;
         end
         else if (push && !full_reg[i] && ((i == 0) || full_reg[i-1]))
            slot_reg[i] <= in_data;
      end
   end

endmodule
`default_nettype wire

// ---- design/hbp_host_port.sv ----
/*
   Host byte port pins of a signal processor: register select, direction,
   strobe, open-drain service request and acknowledge, or fifteen
   general-purpose bits when the port is not in use.
   Assumes all pad inputs are synchronous to clock and that the host keeps
   its inputs stable from strobe assertion until the strobe is fully high.
*/
`timescale 1ns/10ps
`default_nettype none
`include "hbp_defs.svh"

module hbp_host_port
(
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic        port_enable,
   input  wire logic        dma_mode,
   input  wire logic        rx_request_enable,
   input  wire logic        overrun_clear,
   input  wire logic [7:0]  int_vector,
   input  wire logic [14:0] gpio_out,
   input  wire logic [14:0] gpio_oe,
   output var  logic [14:0] gpio_in,
   input  wire logic        tx_valid,
   output var  logic        tx_ready,
   input  wire logic [7:0]  tx_data,
   output var  logic        rx_valid,
   input  wire logic        rx_ready,
   output var  logic [7:0]  rx_data,
   output var  logic        overrun,
   input  wire logic [7:0]  host_byte_lines_in,
   output var  logic [7:0]  host_byte_lines_out,
   output var  logic [7:0]  host_byte_lines_oe,
   input  wire logic [2:0]  host_register_select_in,
   output var  logic [2:0]  host_register_select_out,
   output var  logic [2:0]  host_register_select_oe,
   input  wire logic        host_direction_select_in,
   output var  logic        host_direction_select_out,
   output var  logic        host_direction_select_oe,
   input  wire logic        host_transfer_strobe_n_in,
   output var  logic        host_transfer_strobe_n_out,
   output var  logic        host_transfer_strobe_n_oe,
   input  wire logic        host_service_request_n_in,
   output var  logic        host_service_request_n_out,
   output var  logic        host_service_request_n_oe,
   input  wire logic        host_acknowledge_in_n_in,
   output var  logic        host_acknowledge_in_n_out,
   output var  logic        host_acknowledge_in_n_oe
);

   logic              host_mode_reg;
   logic              act;
   logic              act_reg;
   logic              acc_end;
   logic              rd_drive;
   logic              vec_acc;
   logic [2:0]        eff_sel;
   logic [7:0]        rd_byte;
   logic              req_active;
   logic [14:0]       pad_in;
   logic [14:0]       pad_out;
   logic [14:0]       pad_oe;
   logic [14:0]       host_drive;
   logic [14:0]       host_value;
   hbp_pkg::hbp_access_t kind_reg;
   logic [2:0]        sel_hold_reg;
   logic [7:0]        byte_hold_reg;
   logic              tx_empty_reg;
   logic [7:0]        tx_byte_reg;
   logic              push;
   logic              buf_in_ready;
   logic              overrun_reg;

   // Pins gathered into one vector in general-purpose bit order.
   assign pad_in = {host_acknowledge_in_n_in, host_service_request_n_in,
                    host_transfer_strobe_n_in, host_direction_select_in,
                    host_register_select_in, host_byte_lines_in};

   // Port mode is taken once per cycle; reset selects general inputs.
   always_ff @(posedge clock)
   begin
      if (!rst_n)
         host_mode_reg <= 1'b0;
      else
         host_mode_reg <= port_enable;
   end

   // An access is open while the strobe, or the acknowledge, is low.
   assign vec_acc  = ~dma_mode & ~pad_in[`HBP_PIN_ACK];
   assign act      = host_mode_reg & (~pad_in[`HBP_PIN_STB] |
                                      ~pad_in[`HBP_PIN_ACK]);
   assign rd_drive = act & pad_in[`HBP_PIN_DIR];
   assign acc_end  = act_reg & ~act;
   assign eff_sel  = pad_in[`HBP_PIN_ACK]
                     ? pad_in[`HBP_PIN_SEL_HI:`HBP_PIN_SEL_LO]
                     : `HBP_SEL_DATA;

   // Read data: the acknowledge cycle of an interrupting host sees the
   // vector, a DMA acknowledge the data register, everything else the register that the select lines name.
   always_comb
   begin
      rd_byte = `HBP_BYTE_RST;
      if (vec_acc)
         rd_byte = int_vector;
      else
      begin
         case (eff_sel)
            `HBP_SEL_DATA:
               rd_byte = tx_byte_reg;
            `HBP_SEL_STATUS:
            begin
               rd_byte[`HBP_STAT_TX_FULL]  = ~tx_empty_reg;
               rd_byte[`HBP_STAT_RX_SPACE] = buf_in_ready;
               rd_byte[`HBP_STAT_OVERRUN]  = overrun_reg;
            end
            default:
               rd_byte = `HBP_BYTE_RST;
         endcase
      end
   end

   // Access tracking. Holding the byte every low cycle means a strobe that
   // rises in a cycle still latches what the host held while it was low.
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         act_reg       <= 1'b0;
         kind_reg      <= hbp_pkg::HBP_ACC_NONE;
         sel_hold_reg  <= `HBP_SEL_RST;
         byte_hold_reg <= `HBP_BYTE_RST;
      end
      else
      begin
         act_reg <= act;
         if (act)
         begin
            sel_hold_reg <= vec_acc ? `HBP_SEL_STATUS : eff_sel;
            kind_reg     <= pad_in[`HBP_PIN_DIR] ? hbp_pkg::HBP_ACC_READ
                                                 : hbp_pkg::HBP_ACC_WRITE;
            if (!pad_in[`HBP_PIN_DIR])
               byte_hold_reg <= pad_in[`HBP_PIN_BYTE_HI:`HBP_PIN_BYTE_LO];
         end
         else
            kind_reg <= hbp_pkg::HBP_ACC_NONE;
      end
   end

   // Outgoing byte: loaded by the core, emptied by a host data read.
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         tx_empty_reg <= 1'b1;
         tx_byte_reg  <= `HBP_BYTE_RST;
      end
      else if (acc_end && kind_reg == hbp_pkg::HBP_ACC_READ &&
               sel_hold_reg == `HBP_SEL_DATA)
         tx_empty_reg <= 1'b1;
      else if (tx_valid && tx_empty_reg)
      begin
         tx_empty_reg <= 1'b0;
         tx_byte_reg  <= tx_data;
      end
   end
   assign tx_ready = tx_empty_reg;

   // Host writes to the data register enter the buffer at strobe or acknowledge release.
   assign push = acc_end && kind_reg == hbp_pkg::HBP_ACC_WRITE &&
                 sel_hold_reg == `HBP_SEL_DATA;

   hbp_pair_buf #(
      .WIDTH (8),
      .DEPTH (2)
   ) u_rx_buf (
      .clock     (clock),
      .rst_n     (rst_n),
      .in_valid  (push),
      .in_ready  (buf_in_ready),
      .in_data   (byte_hold_reg),
      .out_valid (rx_valid),
      .out_ready (rx_ready),
      .out_data  (rx_data)
   );

   // The host cannot be stalled, so a write into a full buffer is dropped
   // and flagged; a new drop wins over a clear in the same cycle.
   always_ff @(posedge clock)
   begin
      if (!rst_n)
         overrun_reg <= 1'b0;
      else if (push && !buf_in_ready)
         overrun_reg <= 1'b1;
      else if (overrun_clear)
         overrun_reg <= 1'b0;
   end
   assign overrun = overrun_reg;

   // Service wanted when a byte waits for the host or, with rx_request_enable set, room waits for one.
   assign req_active = ~tx_empty_reg | (rx_request_enable & buf_in_ready);

   // Host-side drive per pin; only the byte lines and request ever drive.
   always_comb
   begin
      host_drive = '0;
      host_value = '0;
      host_drive[`HBP_PIN_BYTE_HI:`HBP_PIN_BYTE_LO] = {8{rd_drive}};
      host_value[`HBP_PIN_BYTE_HI:`HBP_PIN_BYTE_LO] = rd_byte;
      host_drive[`HBP_PIN_REQ] = 1'b1;
      host_value[`HBP_PIN_REQ] = ~req_active;
   end

   // One cell per pin; the request cell alone is open drain in host mode.
   for (genvar i = 0; i < `HBP_PIN_COUNT; i++)
   begin : g_pin
      hbp_pin_cell #(
         .OPEN_DRAIN (i == `HBP_PIN_REQ)
      ) u_cell (
         .clock      (clock),
         .rst_n      (rst_n),
         .host_mode  (host_mode_reg),
         .host_drive (host_drive[i]),
         .host_value (host_value[i]),
         .gpio_oe    (gpio_oe[i]),
         .gpio_value (gpio_out[i]),
         .pad_in     (pad_in[i]),
         .pad_out    (pad_out[i]),
         .pad_oe     (pad_oe[i]),
         .gpio_in    (gpio_in[i])
      );
   end

   // Pin outputs straight from the cell flops.
   assign host_byte_lines_out        = pad_out[`HBP_PIN_BYTE_HI:0];
   assign host_byte_lines_oe         = pad_oe[`HBP_PIN_BYTE_HI:0];
   assign host_register_select_out   = pad_out[`HBP_PIN_SEL_HI:`HBP_PIN_SEL_LO];
   assign host_register_select_oe    = pad_oe[`HBP_PIN_SEL_HI:`HBP_PIN_SEL_LO];
   assign host_direction_select_out  = pad_out[`HBP_PIN_DIR];
   assign host_direction_select_oe   = pad_oe[`HBP_PIN_DIR];
   assign host_transfer_strobe_n_out = pad_out[`HBP_PIN_STB];
   assign host_transfer_strobe_n_oe  = pad_oe[`HBP_PIN_STB];
   assign host_service_request_n_out = pad_out[`HBP_PIN_REQ];
   assign host_service_request_n_oe  = pad_oe[`HBP_PIN_REQ];
   assign host_acknowledge_in_n_out  = pad_out[`HBP_PIN_ACK];
   assign host_acknowledge_in_n_oe   = pad_oe[`HBP_PIN_ACK];

   // Checks of pin behaviour against its cause.
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   sequence host_read_open;
      host_mode_reg && act && pad_in[`HBP_PIN_DIR];
   endsequence

   sequence host_read_done;
      acc_end && kind_reg == hbp_pkg::HBP_ACC_READ;
   endsequence

   lines_input_a: assert property ((host_mode_reg && !rd_drive) |=>
      host_byte_lines_oe == `HBP_OE_NONE)
      else $error("Byte lines driven outside a host read.");

   // A write to any register but data must leave the buffer untouched;
   // with no pop in the same cycle its head and valid cannot move.
   select_decode_a: assert property ((acc_end &&
      kind_reg == hbp_pkg::HBP_ACC_WRITE &&
      sel_hold_reg != `HBP_SEL_DATA && !rx_ready) |=>
      $stable(rx_valid) && $stable(rx_data))
      else $error("Write to a non-data register entered the buffer.");

   read_drive_a: assert property (host_read_open |=>
      host_byte_lines_oe == `HBP_OE_ALL &&
      host_byte_lines_out == $past(rd_byte))
      else $error("Host read did not drive the selected byte.");

   write_latch_a: assert property ((push && buf_in_ready && !rx_valid)
      |=> rx_valid && rx_data == $past(byte_hold_reg))
      else $error("Host write byte not latched at strobe release.");

   request_low_a: assert property ((host_mode_reg && !tx_empty_reg)
      |=> host_service_request_n_oe && !host_service_request_n_out)
      else $error("Service request not pulled low with a byte waiting.");

   request_push_a: assert property ((!host_mode_reg &&
      gpio_oe[`HBP_PIN_REQ]) |=> host_service_request_n_oe &&
      host_service_request_n_out == $past(gpio_out[`HBP_PIN_REQ]))
      else $error("Request pin as general bit not driven push-pull.");

   ack_vector_a: assert property ((host_mode_reg && vec_acc &&
      pad_in[`HBP_PIN_DIR]) |=> host_byte_lines_out == $past(int_vector))
      else $error("Interrupt acknowledge did not present the vector.");

   gpio_map_a: assert property (!host_mode_reg |=>
      pad_oe == $past(gpio_oe) && pad_out == $past(gpio_out))
      else $error("General-purpose bits not following their controls.");

   reset_input_a: assert property ($rose(rst_n) |->
      pad_oe == 15'h0000 && !host_mode_reg)
      else $error("A pin was driven straight after reset.");

   read_release_a: assert property (host_read_done |=>
      host_byte_lines_oe == `HBP_OE_NONE)
      else $error("Byte lines still driven after the read strobe ended.");

endmodule
`default_nettype wire

// ---- testbench/hbp_host_model.sv ----
/*
   Host-side model of the byte port: one access at a time, opened by the
   strobe or by the acknowledge line.
   Assumes the bench resolves every pin from both parties' drive.
*/
`timescale 1ns/10ps
`default_nettype none

module hbp_host_model
(
   input  wire logic       clock,
   input  wire logic [7:0] byte_oe,
   input  wire logic [7:0] byte_pin,
   output var  logic [7:0] host_byte,
   output var  logic [2:0] host_sel,
   output var  logic       host_dir,
   output var  logic       host_stb_n,
   output var  logic       host_ack_n
);
   // Idle host: nothing open, byte lines not driven.
   initial
   begin
      host_byte  = 8'h00;
      host_sel   = 3'h0;
      host_dir   = 1'b0;
      host_stb_n = 1'b1;
      host_ack_n = 1'b1;
   end

   // One access. Released byte lines show the inverse of the last byte,
   // so a stale value can never pass for a fresh one.
   task automatic xfer(input logic ack, input logic rd,
      input logic [2:0] sel, input logic [7:0] wd,
      output logic [7:0] rv, output logic ok);
      int n;
      n = 0;
      @(posedge clock);
      host_sel <= sel;
      host_dir <= rd;
      if (!rd)
         host_byte <= wd;
      if (ack)
         host_ack_n <= 1'b0;
      else
         host_stb_n <= 1'b0;
      do
      begin
         @(posedge clock);
         n++;
      end
      while (rd && byte_oe !== 8'hFF && n < 8);
      ok = !rd || (byte_oe === 8'hFF);
      rv = byte_pin;
      host_stb_n <= 1'b1;
      host_ack_n <= 1'b1;
      // Select, direction and byte stay put until the strobe is seen high.
      repeat (2) @(posedge clock);
      if (!rd)
         host_byte <= ~host_byte;
   endtask
endmodule

`default_nettype wire

// ---- testbench/tb.sv ----
/*
   Self-checking bench of the host byte port with a host model on the pins.
   Assumes the design is driven from one 100 MHz clock.
*/
`timescale 1ns/10ps
`default_nettype none
`include "hbp_defs.svh"

module tb;
   logic        clock, rst_n, port_enable, dma_mode, rx_request_enable;
   logic        overrun_clear, tx_valid, tx_ready, rx_valid, rx_ready;
   logic        overrun, ok;
   logic [7:0]  int_vector, tx_data, rx_data, v, h_byte;
   logic [14:0] gpio_out, gpio_oe, gpio_in, dev_out, dev_oe, host_v, pin;
   logic [7:0]  host_byte_lines_out, host_byte_lines_oe;
   logic [2:0]  host_register_select_out, host_register_select_oe, h_sel;
   logic        host_direction_select_out, host_direction_select_oe;
   logic        host_transfer_strobe_n_out, host_transfer_strobe_n_oe;
   logic        host_service_request_n_out, host_service_request_n_oe;
   logic        host_acknowledge_in_n_out, host_acknowledge_in_n_oe;
   logic        h_dir, h_stb_n, h_ack_n;
   int          n_errors, checks_done, cycles;

   // Wire levels: the device wins where it drives, the request line has a
   // pull-up, every other line shows what the host puts on it.
   assign dev_out = {host_acknowledge_in_n_out, host_service_request_n_out,
      host_transfer_strobe_n_out, host_direction_select_out,
      host_register_select_out, host_byte_lines_out};
   assign dev_oe  = {host_acknowledge_in_n_oe, host_service_request_n_oe,
      host_transfer_strobe_n_oe, host_direction_select_oe,
      host_register_select_oe, host_byte_lines_oe};
   assign host_v  = {h_ack_n, 1'b1, h_stb_n, h_dir, h_sel, h_byte};
   assign pin     = (dev_oe & dev_out) | (~dev_oe & host_v);

   hbp_host_port hbp_host_port_i
   (
      .clock, .rst_n, .port_enable, .dma_mode, .rx_request_enable,
      .overrun_clear, .int_vector, .gpio_out, .gpio_oe, .gpio_in,
      .tx_valid, .tx_ready, .tx_data, .rx_valid, .rx_ready, .rx_data,
      .overrun, .host_byte_lines_in(pin[7:0]), .host_byte_lines_out,
      .host_byte_lines_oe, .host_register_select_in(pin[10:8]),
      .host_register_select_out, .host_register_select_oe,
      .host_direction_select_in(pin[11]), .host_direction_select_out,
      .host_direction_select_oe, .host_transfer_strobe_n_in(pin[12]),
      .host_transfer_strobe_n_out, .host_transfer_strobe_n_oe,
      .host_service_request_n_in(pin[13]), .host_service_request_n_out,
      .host_service_request_n_oe, .host_acknowledge_in_n_in(pin[14]),
      .host_acknowledge_in_n_out, .host_acknowledge_in_n_oe
   );

   hbp_host_model hbp_host_model_i
   (
      .clock(clock), .byte_oe(host_byte_lines_oe), .byte_pin(pin[7:0]),
      .host_byte(h_byte), .host_sel(h_sel), .host_dir(h_dir),
      .host_stb_n(h_stb_n), .host_ack_n(h_ack_n)
   );

   // Free-running 100 MHz clock.
   always #5 clock = ~clock;

   // A hang ends the run as a failure; the tests need about a hundred cycles.
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         n_errors++;
         give_verdict();
      end
   end

   task automatic chk(input string what, input logic [15:0] seen,
      input logic [15:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic give_verdict();
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic push_tx(input logic [7:0] d);
      @(posedge clock);
      tx_valid <= 1'b1;
      tx_data  <= d;
      @(posedge clock);
      while (tx_ready !== 1'b1)
         @(posedge clock);
      tx_valid <= 1'b0;
   endtask

   task automatic pop_rx(input logic [7:0] e);
      @(posedge clock);
      rx_ready <= 1'b1;
      @(posedge clock);
      while (rx_valid !== 1'b1)
         @(posedge clock);
      chk("rx byte", rx_data, e);
      rx_ready <= 1'b0;
   endtask

   // Host read of a waiting byte, with service request before and after.
   task automatic s_read();
      chk("request idle", host_service_request_n_oe, 1'b0);
      push_tx(8'hA5);
      repeat (3) @(posedge clock);
      chk("request on", {host_service_request_n_oe,
         host_service_request_n_out}, 2'b10);
      hbp_host_model_i.xfer(1'b0, 1'b1, `HBP_SEL_DATA, 8'h00, v, ok);
      chk("read drive", ok, 1'b1);
      chk("read byte", v, 8'hA5);
      repeat (2) @(posedge clock);
      chk("read release", host_byte_lines_oe, `HBP_OE_NONE);
      chk("tx slot free", tx_ready, 1'b1);
      chk("request off", host_service_request_n_oe, 1'b0);
   endtask

   // Three writes into a stalled two-entry buffer, status and drain.
   task automatic s_write();
      logic [7:0] b [3] = '{8'h11, 8'h22, 8'h33};
      foreach (b[i])
      begin
         hbp_host_model_i.xfer(1'b0, 1'b0, `HBP_SEL_DATA, b[i], v, ok);
         chk("write no drive", host_byte_lines_oe, `HBP_OE_NONE);
      end
      repeat (3) @(posedge clock);
      chk("overrun set", overrun, 1'b1);
      hbp_host_model_i.xfer(1'b0, 1'b1, `HBP_SEL_STATUS, 8'h00, v, ok);
      chk("status full", v, 8'h04);
      pop_rx(8'h11);
      pop_rx(8'h22);
      @(posedge clock);
      chk("rx empty", rx_valid, 1'b0);
      overrun_clear <= 1'b1;
      @(posedge clock);
      overrun_clear <= 1'b0;
      @(posedge clock);
      chk("overrun clear", overrun, 1'b0);
      hbp_host_model_i.xfer(1'b0, 1'b1, `HBP_SEL_STATUS, 8'h00, v, ok);
      chk("status room", v, 8'h02);
      hbp_host_model_i.xfer(1'b0, 1'b1, 3'h5, 8'h00, v, ok);
      chk("unmapped read", v, 8'h00);
      // A strobed write to the status register must not reach the buffer.
      hbp_host_model_i.xfer(1'b0, 1'b0, `HBP_SEL_STATUS, 8'h99, v, ok);
      repeat (2) @(posedge clock);
      chk("status write ignored", rx_valid, 1'b0);
   endtask

   // Acknowledge as interrupt vector fetch and as DMA handshake.
   task automatic s_ack();
      hbp_host_model_i.xfer(1'b1, 1'b1, `HBP_SEL_DATA, 8'h00, v, ok);
      chk("int vector", v, 8'h3C);
      @(posedge clock);
      dma_mode <= 1'b1;
      push_tx(8'h5A);
      hbp_host_model_i.xfer(1'b1, 1'b1, `HBP_SEL_STATUS, 8'h00, v, ok);
      chk("dma read", v, 8'h5A);
      hbp_host_model_i.xfer(1'b1, 1'b0, `HBP_SEL_STATUS, 8'h77, v, ok);
      pop_rx(8'h77);
      rx_request_enable <= 1'b1;
      repeat (3) @(posedge clock);
      chk("request room", {host_service_request_n_oe,
         host_service_request_n_out}, 2'b10);
      rx_request_enable <= 1'b0;
   endtask

   // Pins as general bits, then a reset in mid-drive.
   task automatic s_gpio();
      @(posedge clock);
      port_enable <= 1'b0;
      gpio_oe     <= 15'h7FFF;
      gpio_out    <= 15'h2A5A;
      repeat (3) @(posedge clock);
      chk("gpio oe", dev_oe, 15'h7FFF);
      chk("gpio out", dev_out, 15'h2A5A);
      chk("request push", {host_service_request_n_oe,
         host_service_request_n_out}, 2'b11);
      gpio_oe <= 15'h0000;
      repeat (3) @(posedge clock);
      chk("gpio in", gpio_in, host_v);
      gpio_oe <= 15'h7FFF;
      repeat (3) @(posedge clock);
      rst_n <= 1'b0;
      repeat (2) @(posedge clock);
      chk("reset no drive", dev_oe, 15'h0000);
      rst_n   <= 1'b1;
      gpio_oe <= 15'h0000;
      repeat (2) @(posedge clock);
      chk("after reset oe", dev_oe, 15'h0000);
      chk("reset tx ready", tx_ready, 1'b1);
      chk("reset rx empty", rx_valid, 1'b0);
   endtask

   // Reset with every general enable set: nothing may drive meanwhile.
   initial
   begin
      clock = 1'b0;
      rst_n = 1'b0;
      port_enable = 1'b0;
      dma_mode = 1'b0;
      rx_request_enable = 1'b0;
      overrun_clear = 1'b0;
      int_vector = 8'h3C;
      gpio_out = 15'h7FFF;
      gpio_oe = 15'h7FFF;
      tx_valid = 1'b0;
      tx_data = 8'h00;
      rx_ready = 1'b0;
      n_errors = 0;
      checks_done = 0;
      cycles = 0;
      repeat (16) @(posedge clock);
      chk("reset oe", dev_oe, 15'h0000);
      rst_n       <= 1'b1;
      port_enable <= 1'b1;
      gpio_oe     <= 15'h0000;
      repeat (3) @(posedge clock);
      chk("data lines idle", host_byte_lines_oe, `HBP_OE_NONE);
      s_read();
      s_write();
      s_ack();
      s_gpio();
      give_verdict();
   end
endmodule

`default_nettype wire
